// ---- cief_pkg.sv ----
// Constants, types and register layout of the comparator interrupt enable and flag block.
// Assumes a single 50 MHz clock domain and an AXI4-Lite master on the register side.
package cief_pkg;

   localparam int CIEF_ADDR_W = 8;
   localparam int CIEF_DATA_W = 32;
   localparam int CIEF_STRB_W = CIEF_DATA_W / 8;
   localparam int CIEF_REG_W = 8;
   localparam int CIEF_NUM_COMP = 2;

   localparam logic [CIEF_ADDR_W-1:0] CIEF_OFS_FLAGS = 8'h0C;
   localparam logic [CIEF_ADDR_W-1:0] CIEF_OFS_ENABLES = 8'h8C;
   localparam int CIEF_WORD_LSB = 2;

   localparam int CIEF_BIT_COMP = 6;
   localparam logic [CIEF_REG_W-1:0] CIEF_IMPL_MASK = 8'h40;
   localparam int CIEF_LANE_COMP = 0;

   localparam logic CIEF_ENABLE_RST = 1'h0;
   localparam logic CIEF_FLAG_RST = 1'h0;

   localparam logic [1:0] CIEF_RESP_OKAY = 2'h0;
   localparam logic [1:0] CIEF_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_FLAGS = 2'b01,
      SEL_ENABLES = 2'b10
   } cief_sel_e;

   typedef enum logic {
      WR_IDLE = 1'b0,
      WR_RESP = 1'b1
   } cief_wr_e;

   typedef enum logic {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } cief_rd_e;

   typedef struct packed {
      logic enable;
      logic flag;
   } cief_bits_s;

   typedef struct packed {
      logic [CIEF_ADDR_W-1:0] addr;
      logic [CIEF_DATA_W-1:0] data;
      logic [CIEF_STRB_W-1:0] strb;
   } cief_wreq_s;

endpackage : cief_pkg

// ---- cief_change_detect.sv ----
// Synchroniser and change detector for the comparator outputs.
// Assumes the comparator outputs are asynchronous levels from the analog block.
`timescale 1ns/10ps
module cief_change_detect
   import cief_pkg::*;
#(
   parameter int NUM_COMP = CIEF_NUM_COMP
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_COMP-1:0] compIn,
   output logic changePulse
);

   logic [NUM_COMP-1:0] syncFirst;
   logic [NUM_COMP-1:0] syncSecond;
   logic [NUM_COMP-1:0] prevLevel;
   logic [NUM_COMP-1:0] next_prevLevel;
   logic next_changePulse;
   logic primeFirst;
   logic primeSecond;
   logic prevValid;
   logic next_primeFirst;
   logic next_primeSecond;
   logic next_prevValid;

   ////////////////////////////////////////////////////////////////////////////////
   // The first stage feeds only the second, so a metastable value never reaches logic.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_COMP; gi++) begin : gSync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               syncFirst[gi] <= 1'h0;
               syncSecond[gi] <= 1'h0;
            end else begin
               syncFirst[gi] <= compIn[gi];
               syncSecond[gi] <= syncFirst[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Edges are only reported once the stored level is a real sample, so a pin that idles high
   // does not fake a change after reset; a change before the first clock edge after reset is not reported.
   always_comb begin
      next_primeFirst = 1'b1;
      next_primeSecond = primeFirst;
      next_prevValid = primeSecond;
      next_prevLevel = syncSecond;
      next_changePulse = prevValid && (|(syncSecond ^ prevLevel));
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         primeFirst <= 1'h0;
         primeSecond <= 1'h0;
         prevValid <= 1'h0;
         prevLevel <= '0;
         changePulse <= 1'h0;
      end else begin
         primeFirst <= next_primeFirst;
         primeSecond <= next_primeSecond;
         prevValid <= next_prevValid;
         prevLevel <= next_prevLevel;
         changePulse <= next_changePulse;
      end
   end

endmodule : cief_change_detect

// ---- cief_top.sv ----
// Comparator interrupt enable and flag registers behind an AXI4-Lite slave.
// Assumes a 50 MHz clock, an asynchronous active-high reset and comparator levels from outside.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps

// How it works
// - Bit 6 of the enable register turns the comparator interrupt on when written 1 and off when 0.
// - Bit 6 of the flag register goes to 1 when a comparator output changes or software writes 1, and stays 1 until software writes 0.
// - The flag is set by a change whatever the enable bit happens to be.
// - Bits 7 and 5 to 0 of both registers drop writes and read as zero.
// - The enable bit lives in its own register and software can read and write it.
module cief_top
   import cief_pkg::*;
#(
   parameter int NUM_COMP = CIEF_NUM_COMP
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_COMP-1:0] compIn,
   input wire logic [CIEF_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [CIEF_DATA_W-1:0] s_axi_wdata,
   input wire logic [CIEF_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CIEF_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [CIEF_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irqRequest
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decoding is shared by the read and write paths; the low two address bits are ignored.
   function automatic cief_sel_e regSelect(input logic [CIEF_ADDR_W-1:0] addr);
      if (addr[CIEF_ADDR_W-1:CIEF_WORD_LSB] == CIEF_OFS_FLAGS[CIEF_ADDR_W-1:CIEF_WORD_LSB]) begin
         return SEL_FLAGS;
      end else if (addr[CIEF_ADDR_W-1:CIEF_WORD_LSB]
                   == CIEF_OFS_ENABLES[CIEF_ADDR_W-1:CIEF_WORD_LSB]) begin
         return SEL_ENABLES;
      end
      return SEL_NONE;
   endfunction : regSelect

   function automatic logic [CIEF_DATA_W-1:0] readValue(input cief_sel_e sel,
                                                        input cief_bits_s bitsNow);
      logic [CIEF_REG_W-1:0] byteVal;
      byteVal = '0;
      unique case (sel)
         SEL_FLAGS: byteVal = bitsNow.flag ? CIEF_IMPL_MASK : '0;
         SEL_ENABLES: byteVal = bitsNow.enable ? CIEF_IMPL_MASK : '0;
         SEL_NONE: byteVal = '0;
      endcase
      return {{(CIEF_DATA_W-CIEF_REG_W){1'b0}}, byteVal};
   endfunction : readValue

   ////////////////////////////////////////////////////////////////////////////////
   logic changeEvent;

   cief_change_detect #(
      .NUM_COMP(NUM_COMP)
   ) uChange (
      .clk(clk),
      .rst(rst),
      .compIn(compIn),
      .changePulse(changeEvent)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken in either order, then one response.
   cief_wr_e wrState;
   cief_wr_e next_wrState;
   logic awHeld;
   logic next_awHeld;
   logic wHeld;
   logic next_wHeld;
   cief_wreq_s wrReq;
   cief_wreq_s next_wrReq;
   cief_wreq_s curReq;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic doWrite;
   logic awFire;
   logic wFire;
   cief_sel_e wrSel;

   assign awFire = s_axi_awvalid && s_axi_awready;
   assign wFire = s_axi_wvalid && s_axi_wready;
   assign wrSel = regSelect(curReq.addr);

   always_comb begin
      next_wrState = wrState;
      next_awHeld = awHeld;
      next_wHeld = wHeld;
      next_wrReq = wrReq;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      doWrite = 1'b0;
      if (awFire) begin
         next_awHeld = 1'b1;
         next_wrReq.addr = s_axi_awaddr;
      end
      if (wFire) begin
         next_wHeld = 1'b1;
         next_wrReq.data = s_axi_wdata;
         next_wrReq.strb = s_axi_wstrb;
      end
      curReq = next_wrReq;
      unique case (wrState)
         WR_IDLE: begin
            if (next_awHeld && next_wHeld) begin
               doWrite = 1'b1;
               next_wrState = WR_RESP;
               next_bvalid = 1'b1;
               next_bresp = (regSelect(curReq.addr) == SEL_NONE) ? CIEF_RESP_SLVERR
                                                                 : CIEF_RESP_OKAY;
               next_awHeld = 1'b0;
               next_wHeld = 1'b0;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_bvalid = 1'b0;
               next_wrState = WR_IDLE;
            end
         end
      endcase
      next_awready = (next_wrState == WR_IDLE) && !next_awHeld;
      next_wready = (next_wrState == WR_IDLE) && !next_wHeld;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrState <= WR_IDLE;
         awHeld <= 1'h0;
         wHeld <= 1'h0;
         wrReq <= '0;
         s_axi_awready <= 1'h0;
         s_axi_wready <= 1'h0;
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= CIEF_RESP_OKAY;
      end else begin
         wrState <= next_wrState;
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         wrReq <= next_wrReq;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt bits. A change in the same cycle as a clearing write keeps the flag set,
   // so an event is never lost to a racing software clear.
   cief_bits_s bits;
   cief_bits_s next_bits;
   logic next_irq;
   logic laneHit;

   assign laneHit = curReq.strb[CIEF_LANE_COMP];

   always_comb begin
      next_bits = bits;
      if (doWrite && laneHit) begin
         unique case (wrSel)
            SEL_FLAGS: next_bits.flag = curReq.data[CIEF_BIT_COMP];
            SEL_ENABLES: next_bits.enable = curReq.data[CIEF_BIT_COMP];
            SEL_NONE: next_bits = bits;
         endcase
      end
      if (changeEvent) begin
         next_bits.flag = 1'b1;
      end
      next_irq = next_bits.flag && next_bits.enable;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bits.enable <= CIEF_ENABLE_RST;
         bits.flag <= CIEF_FLAG_RST;
         irqRequest <= 1'h0;
      end else begin
         bits <= next_bits;
         irqRequest <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, data one cycle after the address is taken.
   cief_rd_e rdState;
   cief_rd_e next_rdState;
   logic next_arready;
   logic next_rvalid;
   logic [CIEF_DATA_W-1:0] next_rdata;
   logic [1:0] next_rresp;
   logic arFire;
   cief_sel_e rdSel;

   assign arFire = s_axi_arvalid && s_axi_arready;
   assign rdSel = regSelect(s_axi_araddr);

   always_comb begin
      next_rdState = rdState;
      next_arready = s_axi_arready;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      unique case (rdState)
         RD_IDLE: begin
            next_arready = 1'b1;
            if (arFire) begin
               next_rdState = RD_DATA;
               next_arready = 1'b0;
               next_rvalid = 1'b1;
               next_rdata = readValue(rdSel, bits);
               next_rresp = (rdSel == SEL_NONE) ? CIEF_RESP_SLVERR : CIEF_RESP_OKAY;
            end
         end
         RD_DATA: begin
            if (s_axi_rready) begin
               next_rdState = RD_IDLE;
               next_rvalid = 1'b0;
               next_arready = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdState <= RD_IDLE;
         s_axi_arready <= 1'h0;
         s_axi_rvalid <= 1'h0;
         s_axi_rdata <= '0;
         s_axi_rresp <= CIEF_RESP_OKAY;
      end else begin
         rdState <= next_rdState;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the interrupt bits and the bus answers.
   default clocking cbMain @(posedge clk);
   endclocking
   default disable iff (rst);

   logic flagWriteZero;
   logic flagWriteOne;
   logic enableWrite;

   assign flagWriteZero = doWrite && laneHit && wrSel == SEL_FLAGS && !curReq.data[CIEF_BIT_COMP];
   assign flagWriteOne = doWrite && laneHit && wrSel == SEL_FLAGS && curReq.data[CIEF_BIT_COMP];
   assign enableWrite = doWrite && laneHit && wrSel == SEL_ENABLES;

   sequence seqEnableRead;
      arFire && rdSel == SEL_ENABLES;
   endsequence

   sequence seqFlagQuiet;
      !bits.flag && !changeEvent && !flagWriteOne;
   endsequence

   chk_enable_write_takes: assert property (
      enableWrite |=> bits.enable == $past(curReq.data[CIEF_BIT_COMP]))
      else $error("Enable bit did not take the written value.");

   chk_change_sets_flag: assert property (
      changeEvent |=> bits.flag)
      else $error("Comparator change did not set the flag.");

   chk_flag_stays_clear: assert property (
      seqFlagQuiet |=> !bits.flag)
      else $error("Flag rose with no comparator change.");

   chk_flag_when_disabled: assert property (
      changeEvent && !bits.enable && !enableWrite |=> bits.flag && !irqRequest)
      else $error("Disabled source lost its flag or raised a request.");

   chk_reserved_read_zero: assert property (
      s_axi_rvalid |-> (s_axi_rdata[CIEF_REG_W-1:0] & ~CIEF_IMPL_MASK) == '0
                       && s_axi_rdata[CIEF_DATA_W-1:CIEF_REG_W] == '0)
      else $error("Reserved bits read as nonzero.");

   chk_enable_readback: assert property (
      seqEnableRead |=> s_axi_rvalid && s_axi_rdata[CIEF_BIT_COMP] == $past(bits.enable))
      else $error("Enable register read did not return the enable bit.");

   chk_irq_gating: assert property (
      irqRequest |-> bits.flag && bits.enable)
      else $error("Request high without both flag and enable.");

   chk_irq_raise: assert property (
      bits.flag && bits.enable |-> irqRequest)
      else $error("Request low while flag and enable are both set.");

   chk_flag_sticky: assert property (
      bits.flag && !flagWriteZero |=> bits.flag)
      else $error("Flag dropped without a software clear.");

   chk_write_answer: assert property (
      doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("Write was not answered one cycle later.");

   chk_read_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data changed before it was taken.");

endmodule : cief_top

// ---- cief_testbench.sv ----
// Self-checking bench for the comparator interrupt enable and flag block.
// Assumes the package and the top module are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
module testbench
   import cief_pkg::*;
;
   logic clk;
   logic rst;
   logic [CIEF_NUM_COMP-1:0] compIn;
   logic [CIEF_ADDR_W-1:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [CIEF_DATA_W-1:0] s_axi_wdata;
   logic [CIEF_STRB_W-1:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [CIEF_ADDR_W-1:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [CIEF_DATA_W-1:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic irqRequest;
   int nMismatch = 0;
   int testsRun = 0;

   cief_top uut (.clk(clk), .rst(rst), .compIn(compIn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irqRequest(irqRequest));

   ////////////////////////////////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;

   task summarize;
      if (nMismatch == 0 && testsRun > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize

   task cmpWord(input string what, input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmpWord

   task cmpResp(input string what, input logic [1:0] got, input logic [1:0] exp);
      testsRun++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmpResp

   task cmpBit(input string what, input logic got, input logic exp);
      testsRun++;
      if (got !== exp) begin
         nMismatch++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : cmpBit

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Ready and response are looked at on the falling edge, where they equal the value that the
   // next rising edge samples, so no race with the slave's own registers can arise.
   task axiWrite(input logic [CIEF_ADDR_W-1:0] addr, input logic [CIEF_DATA_W-1:0] data,
                 input logic [CIEF_STRB_W-1:0] strb, input logic [1:0] expResp);
      logic awTake;
      logic wTake;
      logic done;
      s_axi_awaddr <= addr;
      s_axi_wdata <= data;
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      done = 1'b0;
      while (!done) begin
         @(negedge clk);
         awTake = s_axi_awvalid & s_axi_awready;
         wTake = s_axi_wvalid & s_axi_wready;
         done = (s_axi_bvalid === 1'h1);
         if (done) cmpResp("bresp", s_axi_bresp, expResp);
         @(posedge clk);
         if (awTake) s_axi_awvalid <= 1'h0;
         if (wTake) s_axi_wvalid <= 1'h0;
         if (done) s_axi_bready <= 1'h0;
      end
      @(posedge clk);
   endtask : axiWrite

   task axiRead(input logic [CIEF_ADDR_W-1:0] addr, input logic [CIEF_DATA_W-1:0] expData,
                input logic [1:0] expResp);
      logic arTake;
      logic done;
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      done = 1'b0;
      while (!done) begin
         @(negedge clk);
         arTake = s_axi_arvalid & s_axi_arready;
         done = (s_axi_rvalid === 1'h1);
         if (done) begin
            cmpWord("rdata", s_axi_rdata, expData);
            cmpResp("rresp", s_axi_rresp, expResp);
         end
         @(posedge clk);
         if (arTake) s_axi_arvalid <= 1'h0;
         if (done) s_axi_rready <= 1'h0;
      end
      @(posedge clk);
   endtask : axiRead

   task checkIrq(input logic exp);
      @(negedge clk);
      cmpBit("irqRequest", irqRequest, exp);
      @(posedge clk);
   endtask : checkIrq

   // The flag shows four edges after the change, through the two-flop synchroniser.
   task flipComp(input int idx);
      compIn[idx] <= ~compIn[idx];
      repeat (4) @(posedge clk);
   endtask : flipComp

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      nMismatch++;
      summarize();
   end

   initial begin
      clk = 1'h0;
      rst = 1'h1;
      compIn = '0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'h0;
      s_axi_wdata = '0;
      s_axi_wstrb = '0;
      s_axi_wvalid = 1'h0;
      s_axi_bready = 1'h0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'h0;
      s_axi_rready = 1'h0;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      axiRead(CIEF_OFS_FLAGS, 32'h0, CIEF_RESP_OKAY);
      axiRead(CIEF_OFS_ENABLES, 32'h0, CIEF_RESP_OKAY);
      checkIrq(1'h0);
      axiWrite(CIEF_OFS_ENABLES, 32'hFFFFFFFF, 4'hF, CIEF_RESP_OKAY);
      axiRead(CIEF_OFS_ENABLES, 32'h40, CIEF_RESP_OKAY);
      axiRead(8'h8F, 32'h40, CIEF_RESP_OKAY);
      axiWrite(CIEF_OFS_FLAGS, 32'hBF, 4'hF, CIEF_RESP_OKAY);
      axiRead(CIEF_OFS_FLAGS, 32'h0, CIEF_RESP_OKAY);
      axiWrite(CIEF_OFS_ENABLES, 32'hBF, 4'hF, CIEF_RESP_OKAY);
      axiRead(CIEF_OFS_ENABLES, 32'h0, CIEF_RESP_OKAY);
      // A change with the enable clear still latches the flag but raises no request.
      flipComp(0);
      checkIrq(1'h0);
      axiRead(CIEF_OFS_FLAGS, 32'h40, CIEF_RESP_OKAY);
      repeat (20) @(posedge clk);
      axiRead(CIEF_OFS_FLAGS, 32'h40, CIEF_RESP_OKAY);
      axiWrite(CIEF_OFS_ENABLES, 32'h40, 4'hF, CIEF_RESP_OKAY);
      checkIrq(1'h1);
      axiWrite(CIEF_OFS_FLAGS, 32'h0, 4'h0, CIEF_RESP_OKAY);
      checkIrq(1'h1);
      axiWrite(CIEF_OFS_FLAGS, 32'h0, 4'hF, CIEF_RESP_OKAY);
      checkIrq(1'h0);
      axiRead(CIEF_OFS_FLAGS, 32'h0, CIEF_RESP_OKAY);
      flipComp(1);
      checkIrq(1'h1);
      // Software order: clear a stale flag first, then enable, so no old event fires.
      axiWrite(CIEF_OFS_ENABLES, 32'h0, 4'hF, CIEF_RESP_OKAY);
      checkIrq(1'h0);
      flipComp(1);
      axiRead(CIEF_OFS_FLAGS, 32'h40, CIEF_RESP_OKAY);
      axiWrite(CIEF_OFS_FLAGS, 32'h0, 4'hF, CIEF_RESP_OKAY);
      axiWrite(CIEF_OFS_ENABLES, 32'h40, 4'hF, CIEF_RESP_OKAY);
      checkIrq(1'h0);
      // Unmapped places answer with an error and change nothing.
      axiRead(8'h10, 32'h0, CIEF_RESP_SLVERR);
      axiWrite(8'h10, 32'h0, 4'hF, CIEF_RESP_SLVERR);
      axiRead(CIEF_OFS_ENABLES, 32'h40, CIEF_RESP_OKAY);
      // Software may set the flag by hand, which raises the request while enabled.
      axiWrite(CIEF_OFS_FLAGS, 32'h40, 4'h1, CIEF_RESP_OKAY);
      checkIrq(1'h1);
      axiWrite(CIEF_OFS_FLAGS, 32'h0, 4'h1, CIEF_RESP_OKAY);
      checkIrq(1'h0);
      // A second reset in mid-run returns both bits to zero.
      flipComp(0);
      checkIrq(1'h1);
      rst <= 1'h1;
      checkIrq(1'h0);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      axiRead(CIEF_OFS_ENABLES, 32'h0, CIEF_RESP_OKAY);
      axiRead(CIEF_OFS_FLAGS, 32'h0, CIEF_RESP_OKAY);
      summarize();
   end
endmodule : testbench
